// ### rtl/fsb_arb_defs.vh
/*
 * Constants for the front side bus priority-agent arbiter.
 * Assumes inclusion by every design file of the arbiter.
 */
`ifndef FSB_ARB_DEFS_VH
`define FSB_ARB_DEFS_VH

// ----------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------
`define ADDR_W 40
`define NUM_AGENTS 4
`define ID_LEAD_CLKS 5
`define GRANT_UNIT_CLKS 8'h04
`define HOLD_UNIT_CLKS 8'h02

// ----------------------------------------------------------------
// I/O ports of interest
// ----------------------------------------------------------------
`define CFG_INDEX_PORT 16'h0CF8
`define CFG_DATA_PORT 16'h0CFC
`define IO_PORT_MSB 15

// ----------------------------------------------------------------
// Request kinds decoded from the request phase
// ----------------------------------------------------------------
`define KIND_W 4
`define K_READ_LINE 4'h0
`define K_READ_INV_LINE 4'h1
`define K_LINE_WRITE 4'h2
`define K_LINE_WRITE_INV 4'h3
`define K_IO_READ 4'h4
`define K_IO_WRITE 4'h5
`define K_RESERVED 4'h6
`define K_SPECIAL 4'h7
`define K_TRACE_MSG 4'h8

// ----------------------------------------------------------------
// Completion codes
// ----------------------------------------------------------------
`define CPL_W 3
`define CPL_NORMAL 3'h0
`define CPL_MASTER_ABORT 3'h1
`define CPL_NOP_DATA 3'h2
`define CPL_TRACE_MSG 3'h3
`define CPL_DEFER 3'h4
`define CPL_PEER_IO 3'h5
`define CPL_LINE_WRITE 3'h6

`endif

// ### rtl/fsb_req_decode.v
/*
 * Request phase decoder: classifies one request into a completion.
 * Assumes request fields are already sampled on the common clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fsb_arb_defs.vh"
module fsb_req_decode
(
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Request
    input wire i_valid,
    input wire [`KIND_W-1:0] i_kind,
    input wire [`ADDR_W-1:0] i_addr,
    input wire i_req_a0,
    input wire i_defer_phase_enable,
    input wire i_inbound,
    // Result
    output reg o_valid,
    output reg [`CPL_W-1:0] o_cpl,
    output reg o_cfg_abort
);
    reg [`CPL_W-1:0] cpl_d;
    reg abort_d;
    wire [15:0] io_port;

    assign io_port = {i_addr[`IO_PORT_MSB:3], 3'h0};

    always @*
    begin
        cpl_d = `CPL_NORMAL;
        abort_d = 1'b0;
        case (i_kind)
            `K_IO_READ, `K_IO_WRITE:
            begin
                if (i_inbound && (io_port == `CFG_INDEX_PORT || io_port == `CFG_DATA_PORT))
                begin
                    cpl_d = `CPL_MASTER_ABORT;
                    abort_d = 1'b1;
                end
                else if (i_inbound)
                    cpl_d = `CPL_PEER_IO;
                else
                    cpl_d = `CPL_NORMAL;
            end
            `K_RESERVED:
                cpl_d = i_req_a0 ? `CPL_TRACE_MSG : `CPL_NOP_DATA;
            `K_LINE_WRITE, `K_LINE_WRITE_INV:
                cpl_d = `CPL_LINE_WRITE;
            default:
                cpl_d = `CPL_NORMAL;
        endcase
        if (i_defer_phase_enable && !abort_d)
            cpl_d = `CPL_DEFER;
    end

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_valid <= 1'b0;
            o_cpl <= `CPL_NORMAL;
            o_cfg_abort <= 1'b0;
        end
        else
        begin
            o_valid <= i_valid;
            o_cpl <= cpl_d;
            o_cfg_abort <= i_valid & abort_d;
        end
    end
endmodule
`default_nettype wire

// ### rtl/fsb_defer_strobe.v
/*
 * Deferred reply strobe timing: id strobe leads out of order data.
 * Assumes one deferred reply started per start pulse.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fsb_arb_defs.vh"
module fsb_defer_strobe
#(
    parameter LEAD = `ID_LEAD_CLKS
)
(
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Control
    input wire i_start,
    // Strobes
    output reg o_id_strobe,
    output reg o_out_of_order_data,
    output wire o_busy
);
    reg [3:0] cnt_q;

    assign o_busy = (cnt_q != 4'h0);

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_q <= 4'h0;
            o_id_strobe <= 1'b0;
            o_out_of_order_data <= 1'b0;
        end
        else
        begin
            o_id_strobe <= i_start && !o_busy;
            o_out_of_order_data <= (cnt_q == 4'h1);
            if (i_start && !o_busy)
                cnt_q <= LEAD[3:0];
            else if (o_busy)
                cnt_q <= cnt_q - 4'h1;
        end
    end
endmodule
`default_nettype wire

// ### rtl/fsb_priority_agent_arbiter.v
/*
 * Priority-agent arbiter of the front side bus with request decode.
 * Assumes all agents share i_clk in phase and inputs are synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fsb_arb_defs.vh"
module fsb_priority_agent_arbiter
#(
    parameter AGENTS = `NUM_AGENTS
)
(
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Arbitration pins, sampled on the common clock
    input wire [3:0] i_symmetric_bus_request,
    input wire i_lock,
    input wire i_addr_strobe,
    // Arbitration controls
    input wire [2:0] i_chipset_grant_limit,
    input wire [1:0] i_processor_hold_time,
    input wire i_processor_extra_txn,
    input wire i_debug_block_next,
    input wire i_ecc_mode,
    // Device demand
    input wire i_txn_pending,
    input wire i_snoop_txn,
    input wire i_flow_control,
    // Request phase
    input wire i_req_valid,
    input wire [`KIND_W-1:0] i_req_kind,
    input wire [`ADDR_W-1:0] i_req_addr,
    input wire i_request_field_a0,
    input wire i_defer_phase_enable,
    input wire i_req_inbound,
    input wire [1:0] i_req_agent,
    input wire i_defer_start,
    // Pins driven
    output reg o_priority_bus_request,
    output reg o_block_next_request,
    output reg o_breq0,
    output reg o_breq0_oe_n,
    output reg o_lock_oe_n,
    output reg o_id_strobe,
    output reg o_out_of_order_data,
    output reg o_data_ecc_en,
    output reg o_data_parity_en,
    // Status
    output reg o_cpl_valid,
    output reg [`CPL_W-1:0] o_cpl,
    output reg o_cfg_abort,
    output reg [AGENTS-1:0] o_agent_active,
    output reg o_locked,
    output reg [`ADDR_W-1:0] o_driven_addr
);
    // ----------------------------------------------------------------
    // Arbiter states
    // ----------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_OWN = 2'h1;
    localparam ST_HOLD = 2'h2;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [7:0] cnt_q;
    reg [7:0] cnt_d;
    reg [3:0] breq_q;
    reg extra_q;
    reg extra_d;
    reg rst_seen_q;
    wire cpu_req;
    wire breq_change;
    wire own_want;
    wire dec_valid;
    wire [`CPL_W-1:0] dec_cpl;
    wire dec_abort;
    wire ids;
    wire ood;

    assign cpu_req = |i_symmetric_bus_request;
    assign breq_change = (breq_q != i_symmetric_bus_request);
    assign own_want = i_txn_pending | i_snoop_txn;

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    fsb_req_decode u_dec
    (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_valid(i_req_valid),
        .i_kind(i_req_kind),
        .i_addr(i_req_addr),
        .i_req_a0(i_request_field_a0),
        .i_defer_phase_enable(i_defer_phase_enable),
        .i_inbound(i_req_inbound),
        .o_valid(dec_valid),
        .o_cpl(dec_cpl),
        .o_cfg_abort(dec_abort)
    );

    fsb_defer_strobe #(.LEAD(`ID_LEAD_CLKS)) u_defer
    (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_start(i_defer_start),
        .o_id_strobe(ids),
        .o_out_of_order_data(ood),
        .o_busy()
    );

    // ----------------------------------------------------------------
    // Arbitration state machine
    // ----------------------------------------------------------------
    always @*
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        extra_d = extra_q;
        case (state_q)
            ST_IDLE:
            begin
                if (i_flow_control)
                begin
                    state_d = ST_OWN;
                    cnt_d = 8'h00;
                end
                else if (own_want && !cpu_req)
                begin
                    state_d = ST_OWN;
                    cnt_d = ({5'h00, i_chipset_grant_limit} + 8'h01) * `GRANT_UNIT_CLKS;
                end
                else if (own_want && cpu_req && !i_lock)
                begin
                    state_d = ST_OWN;
                    cnt_d = ({5'h00, i_chipset_grant_limit} + 8'h01) * `GRANT_UNIT_CLKS;
                end
            end
            ST_OWN:
            begin
                if (i_flow_control || i_lock)
                    state_d = ST_OWN;
                else if (!own_want)
                    state_d = ST_IDLE;
                else if (cpu_req && cnt_q <= 8'h01)
                begin
                    state_d = ST_HOLD;
                    cnt_d = ({6'h00, i_processor_hold_time} + 8'h01) * `HOLD_UNIT_CLKS;
                    extra_d = 1'b0;
                end
                else if (cnt_q != 8'h00)
                    cnt_d = cnt_q - 8'h01;
            end
            ST_HOLD:
            begin
                if (breq_change && i_processor_extra_txn && !extra_q)
                    extra_d = 1'b1;
                if (i_flow_control)
                begin
                    state_d = ST_OWN;
                    cnt_d = 8'h00;
                end
                else if (cnt_q > 8'h01)
                    cnt_d = cnt_q - 8'h01;
                else if (extra_q && !i_addr_strobe)
                    state_d = ST_HOLD;
                else
                begin
                    state_d = ST_IDLE;
                    extra_d = 1'b0;
                end
                if (extra_q && i_addr_strobe && cnt_q <= 8'h01)
                    extra_d = 1'b0;
            end
            default:
                state_d = ST_IDLE;
        endcase
    end

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 8'h00;
            extra_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            extra_q <= extra_d;
        end
    end

    // ----------------------------------------------------------------
    // Self-sampled bus lines
    // ----------------------------------------------------------------
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            breq_q <= 4'h0;
            rst_seen_q <= 1'b0;
        end
        else
        begin
            breq_q <= i_symmetric_bus_request;
            rst_seen_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Priority request and debug block
    // ----------------------------------------------------------------
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_priority_bus_request <= 1'b0;
            o_block_next_request <= 1'b0;
        end
        else
        begin
            o_priority_bus_request <= (state_d == ST_OWN);
            o_block_next_request <= i_debug_block_next;
        end
    end

    // ----------------------------------------------------------------
    // Request line zero
    // ----------------------------------------------------------------
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_breq0 <= 1'b1;
            o_breq0_oe_n <= 1'b0;
        end
        else
        begin
            o_breq0 <= 1'b0;
            o_breq0_oe_n <= ~rst_seen_q ? 1'b0 : 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Lock line
    // ----------------------------------------------------------------
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_lock_oe_n <= 1'b1;
            o_locked <= 1'b0;
        end
        else
        begin
            o_lock_oe_n <= 1'b1;
            o_locked <= i_lock;
        end
    end

    // ----------------------------------------------------------------
    // Deferred reply strobes
    // ----------------------------------------------------------------
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_id_strobe <= 1'b0;
            o_out_of_order_data <= 1'b0;
        end
        else
        begin
            o_id_strobe <= ids;
            o_out_of_order_data <= ood;
        end
    end

    // ----------------------------------------------------------------
    // Data protection select
    // ----------------------------------------------------------------
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_data_ecc_en <= 1'b0;
            o_data_parity_en <= 1'b0;
        end
        else
        begin
            o_data_ecc_en <= i_ecc_mode;
            o_data_parity_en <= ~i_ecc_mode;
        end
    end

    // ----------------------------------------------------------------
    // Completion status
    // ----------------------------------------------------------------
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_cpl_valid <= 1'b0;
            o_cpl <= `CPL_NORMAL;
            o_cfg_abort <= 1'b0;
        end
        else
        begin
            o_cpl_valid <= dec_valid;
            o_cpl <= dec_cpl;
            o_cfg_abort <= dec_abort;
        end
    end

    // ----------------------------------------------------------------
    // Logical agent tracking
    // ----------------------------------------------------------------
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_agent_active <= {AGENTS{1'b0}};
        end
        else
        begin
            if (i_req_valid)
                o_agent_active[i_req_agent] <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Driven address tracking
    // ----------------------------------------------------------------
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_driven_addr <= {`ADDR_W{1'b0}};
        end
        else
        begin
            if (state_q == ST_OWN && i_req_valid && !i_req_inbound)
                o_driven_addr <= i_req_addr;
        end
    end
endmodule
`default_nettype wire

// ### bench/fsb_arb_sva.sv
/*
 * Port checker of the priority-agent arbiter.
 * Assumes binding into fsb_priority_agent_arbiter on one clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fsb_arb_defs.vh"
module fsb_arb_sva
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Inputs watched
    input wire logic i_lock,
    input wire logic i_txn_pending,
    input wire logic i_snoop_txn,
    input wire logic i_flow_control,
    input wire logic i_req_valid,
    input wire logic [3:0] i_req_kind,
    input wire logic [39:0] i_req_addr,
    input wire logic i_request_field_a0,
    input wire logic i_defer_phase_enable,
    input wire logic i_req_inbound,
    // Outputs watched
    input wire logic o_priority_bus_request,
    input wire logic o_breq0_oe_n,
    input wire logic o_lock_oe_n,
    input wire logic o_id_strobe,
    input wire logic o_out_of_order_data,
    input wire logic o_data_ecc_en,
    input wire logic o_data_parity_en,
    input wire logic o_cpl_valid,
    input wire logic [2:0] o_cpl,
    input wire logic o_cfg_abort
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire logic plain_req = i_req_valid && !i_req_inbound && !i_defer_phase_enable;
    a_lock_undriven: assert property (o_lock_oe_n)
        else $error("Lock line driven.");
    a_prot_exclusive: assert property (!(o_data_ecc_en && o_data_parity_en))
        else $error("ECC and parity both enabled.");
    a_breq_release: assert property ($fell(i_rst) |-> ##2 o_breq0_oe_n)
        else $error("Request line zero not released.");
    a_breq_stays: assert property (o_breq0_oe_n |=> o_breq0_oe_n)
        else $error("Request line zero driven after reset.");
    a_cfg_abort: assert property (i_req_valid && i_req_inbound &&
        (i_req_kind == `K_IO_READ || i_req_kind == `K_IO_WRITE) && i_req_addr[15:3] == 13'h19F
        |-> ##2 o_cfg_abort && o_cpl_valid && o_cpl == `CPL_MASTER_ABORT)
        else $error("Config port access not aborted.");
    a_defer_resp: assert property (i_req_valid && !i_req_inbound && i_defer_phase_enable
        |-> ##2 o_cpl_valid && o_cpl == `CPL_DEFER) else $error("No deferred response.");
    a_rsv_read: assert property (plain_req && i_req_kind == `K_RESERVED
        && !i_request_field_a0 |-> ##2 o_cpl == `CPL_NOP_DATA) else $error("Bad reserved read.");
    a_rsv_write: assert property (plain_req && i_req_kind == `K_RESERVED
        && i_request_field_a0 |-> ##2 o_cpl == `CPL_TRACE_MSG) else $error("Bad reserved write.");
    a_line_write: assert property (plain_req && i_req_kind == `K_LINE_WRITE_INV
        |-> ##2 o_cpl == `CPL_LINE_WRITE) else $error("Invalidate write not plain.");
    a_ids_lead: assert property ($rose(o_id_strobe) |-> ##5 $rose(o_out_of_order_data))
        else $error("Strobe lead wrong.");
    a_flow_own: assert property (i_flow_control |=> o_priority_bus_request)
        else $error("Flow control did not take the bus.");
    a_idle_release: assert property ((!i_txn_pending && !i_snoop_txn && !i_flow_control
        && !i_lock)[*3] |=> !o_priority_bus_request) else $error("Bus not released.");
    c_abort: cover property (o_cfg_abort);
    c_strobe: cover property (o_out_of_order_data);
    c_own: cover property ($rose(o_priority_bus_request) && i_txn_pending);
endmodule
bind fsb_priority_agent_arbiter fsb_arb_sva u_fsb_arb_sva
(
    .i_clk(i_clk), .i_rst(i_rst), .i_lock(i_lock), .i_txn_pending(i_txn_pending),
    .i_snoop_txn(i_snoop_txn), .i_flow_control(i_flow_control), .i_req_valid(i_req_valid),
    .i_req_kind(i_req_kind), .i_req_addr(i_req_addr), .i_request_field_a0(i_request_field_a0),
    .i_defer_phase_enable(i_defer_phase_enable), .i_req_inbound(i_req_inbound),
    .o_priority_bus_request(o_priority_bus_request), .o_breq0_oe_n(o_breq0_oe_n),
    .o_lock_oe_n(o_lock_oe_n), .o_id_strobe(o_id_strobe),
    .o_out_of_order_data(o_out_of_order_data), .o_data_ecc_en(o_data_ecc_en),
    .o_data_parity_en(o_data_parity_en), .o_cpl_valid(o_cpl_valid), .o_cpl(o_cpl),
    .o_cfg_abort(o_cfg_abort)
);
`default_nettype wire

// ### bench/cpu_agent_model.sv
/*
 * Behavioural symmetric processor agents on the shared bus.
 * Assumes the bench clock and the arbiter's priority request output.
 */
`timescale 1ns/1ps
`default_nettype none
module cpu_agent_model
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Bench control
    input wire logic i_want,
    input wire logic i_want_lock,
    // Bus side
    input wire logic i_prio,
    output logic [3:0] o_breq,
    output logic o_ads,
    output logic o_lock
);
    // ----------------------------------------------------------------
    // Requests, strobes and lock
    // ----------------------------------------------------------------
    // Agents run on the shared clock and never drive the priority request.
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_breq <= 4'h0;
            o_ads <= 1'h0;
            o_lock <= 1'h0;
        end
        else
        begin
            o_breq[0] <= i_want;
            o_breq[1] <= i_want & ~i_prio & ~o_breq[1];
            o_breq[3:2] <= 2'h0;
            o_ads <= i_want & ~i_prio & ~o_ads;
            // Lock follows the bench lock request one clock later.
            o_lock <= i_want_lock;
        end
    end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
/*
 * Self-checking bench of the priority-agent arbiter.
 * Assumes the agent model and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fsb_arb_defs.vh"
module tb_top;
    logic i_clk = 1'h0, i_rst = 1'h1, ext = 1'h0, dbg = 1'h0, ecc = 1'h1, pend = 1'h0;
    logic snp = 1'h0, flow = 1'h0, rv = 1'h0, a0 = 1'h0, dpe = 1'h0, inb = 1'h0, dst = 1'h0;
    logic want = 1'h0, wlock = 1'h0, ads, lck, priority_bus_request, bnr, breq0, breq0_oe_n, lock_oe_n;
    logic ids, ood, ecc_en, par_en, cv, cab, locked;
    logic [2:0] lim = 3'h0, cpl;
    logic [1:0] hold = 2'h0, ag = 2'h0;
    logic [3:0] rk = 4'h0, p_breq, act;
    logic [39:0] ra = 40'h0, daddr;
    int mismatches = 0, n_tests = 0;
    wire logic [3:0] breq_bus = {p_breq[3:1], p_breq[0] | (~breq0_oe_n & breq0)};
    always #4 i_clk = ~i_clk;
    fsb_priority_agent_arbiter u_fsb_priority_agent_arbiter
    (
        .i_clk(i_clk), .i_rst(i_rst), .i_symmetric_bus_request(breq_bus), .i_lock(lck),
        .i_addr_strobe(ads), .i_chipset_grant_limit(lim), .i_processor_hold_time(hold),
        .i_processor_extra_txn(ext), .i_debug_block_next(dbg), .i_ecc_mode(ecc),
        .i_txn_pending(pend), .i_snoop_txn(snp), .i_flow_control(flow), .i_req_valid(rv),
        .i_req_kind(rk), .i_req_addr(ra), .i_request_field_a0(a0),
        .i_defer_phase_enable(dpe), .i_req_inbound(inb), .i_req_agent(ag),
        .i_defer_start(dst), .o_priority_bus_request(priority_bus_request), .o_block_next_request(bnr),
        .o_breq0(breq0), .o_breq0_oe_n(breq0_oe_n), .o_lock_oe_n(lock_oe_n),
        .o_id_strobe(ids), .o_out_of_order_data(ood), .o_data_ecc_en(ecc_en),
        .o_data_parity_en(par_en), .o_cpl_valid(cv), .o_cpl(cpl), .o_cfg_abort(cab),
        .o_agent_active(act), .o_locked(locked), .o_driven_addr(daddr)
    );
    cpu_agent_model u_cpu_agent_model
    (
        .i_clk(i_clk), .i_rst(i_rst), .i_want(want), .i_want_lock(wlock), .i_prio(priority_bus_request),
        .o_breq(p_breq), .o_ads(ads), .o_lock(lck)
    );
    // ----------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d.", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic guard(input int n);
        if (n >= 60)
        begin
            chk("wait bound", 64'h1, 64'h0);
            end_sim();
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_req(input logic [3:0] k, input logic [39:0] a, input logic f, d, i,
        input logic [1:0] g, input logic [2:0] ec, input logic eab);
        @(posedge i_clk);
        rv <= 1'h1;
        rk <= k;
        ra <= a;
        a0 <= f;
        dpe <= d;
        inb <= i;
        ag <= g;
        @(posedge i_clk);
        rv <= 1'h0;
        step(1);
        chk("cpl_valid", cv, 1);
        chk("cpl", cpl, ec);
        chk("cfg_abort", cab, eab);
    endtask
    task automatic t_defer();
        int i, a, b, n;
        a = 0;
        b = 0;
        n = 0;
        @(posedge i_clk);
        dst <= 1'h1;
        for (i = 0; i < 12; i++)
        begin
            @(posedge i_clk);
            dst <= (i == 2);
            #1;
            n += (ids === 1'h1);
            if (ids === 1'h1) a = i;
            if (ood === 1'h1) b = i;
        end
        chk("ids_at", a, 1);
        chk("ood_lead", b - a, 5);
        chk("ids_count", n, 1);
    endtask
    task automatic t_flow();
        @(posedge i_clk);
        flow <= 1'h1;
        want <= 1'h1;
        step(2);
        chk("priority_bus_request_flow", priority_bus_request, 1);
        t_req(`K_READ_LINE, 40'hC012345640, 0, 0, 0, 0, `CPL_NORMAL, 0);
        chk("driven_addr", daddr, 40'hC012345640);
        @(posedge i_clk);
        flow <= 1'h0;
        want <= 1'h0;
        snp <= 1'h1;
        step(4);
        chk("priority_bus_request_snoop", priority_bus_request, 1);
        @(posedge i_clk);
        snp <= 1'h0;
        step(4);
        chk("priority_bus_request_idle", priority_bus_request, 0);
    endtask
    task automatic t_grant(input logic [2:0] l, input logic [1:0] h, input logic x);
        int n, hi, lo;
        @(posedge i_clk);
        lim <= l;
        hold <= h;
        ext <= x;
        pend <= 1'h1;
        want <= 1'h1;
        for (n = 0; n < 60 && priority_bus_request !== 1'h1; n++) step(1);
        guard(n);
        for (hi = 0; hi < 60 && priority_bus_request === 1'h1; hi++) step(1);
        guard(hi);
        for (lo = 0; lo < 60 && priority_bus_request !== 1'h1; lo++) step(1);
        guard(lo);
        @(posedge i_clk);
        pend <= 1'h0;
        want <= 1'h0;
        chk("own_len", hi >= 4 * (l + 1) - 1 && hi <= 4 * (l + 1) + 1, 1);
        chk("hold_len", lo >= 2 * (h + 1), 1);
        step(4);
    endtask
    task automatic t_pins();
        @(posedge i_clk);
        dbg <= 1'h1;
        ecc <= 1'h0;
        wlock <= 1'h1;
        step(4);
        chk("block_next", bnr, 1);
        chk("par_en", {ecc_en, par_en}, 2'h1);
        chk("locked", {locked, lock_oe_n, breq0_oe_n}, 3'h7);
        @(posedge i_clk);
        dbg <= 1'h0;
        wlock <= 1'h0;
        step(3);
    endtask
    initial
    begin
        step(7);
        chk("reset_breq", {breq0, breq0_oe_n, lock_oe_n, breq_bus[0]}, 4'hB);
        @(posedge i_clk);
        i_rst <= 1'h0;
        step(1);
        chk("breq_first", breq0_oe_n, 0);
        step(1);
        chk("breq_off", {breq0_oe_n, ecc_en, par_en, bnr}, 4'hC);
        t_req(`K_IO_READ, 40'h0CF8, 0, 0, 1, 0, `CPL_MASTER_ABORT, 1);
        t_req(`K_IO_WRITE, 40'h0CFC, 0, 1, 1, 1, `CPL_MASTER_ABORT, 1);
        t_req(`K_IO_READ, 40'h1000, 0, 0, 1, 2, `CPL_PEER_IO, 0);
        t_req(`K_READ_INV_LINE, 40'hFF00000040, 0, 1, 0, 3, `CPL_DEFER, 0);
        t_req(`K_READ_INV_LINE, 40'h40, 1, 0, 0, 0, `CPL_NORMAL, 0);
        t_req(`K_LINE_WRITE_INV, 40'h80, 0, 0, 0, 1, `CPL_LINE_WRITE, 0);
        t_req(`K_LINE_WRITE, 40'h80, 1, 0, 0, 2, `CPL_LINE_WRITE, 0);
        t_req(`K_RESERVED, 40'hC0, 0, 0, 0, 3, `CPL_NOP_DATA, 0);
        t_req(`K_RESERVED, 40'hC0, 1, 0, 0, 0, `CPL_TRACE_MSG, 0);
        chk("agents", act, 4'hF);
        t_defer();
        t_flow();
        t_grant(3'h0, 2'h0, 1'h0);
        t_grant(3'h2, 2'h3, 1'h0);
        t_grant(3'h1, 2'h1, 1'h1);
        t_pins();
        end_sim();
    end
endmodule
`default_nettype wire
